//--- samd_datapath.sv
/*
 * samd_datapath: shift-right, load-updated-address and multiply-accumulate
 * execution with its own operand registers, reached over AXI4-Lite.
 * Assumes one clock, a synchronous active-high reset and a master on the
 * same clock; writing the instruction register executes one instruction.
 */
`timescale 1ns/1ns
module samd_datapath (
	input wire logic clk_sys_i, // core clock, 100 MHz
	input wire logic sys_rst_i, // synchronous reset, high
	input wire samd_pkg::samd_axil_req_s axil_req_i, // bus requests
	output samd_pkg::samd_axil_rsp_s axil_rsp_o // bus answers
);
	import samd_pkg::*;

	samd_state_s q, d;

	// ==========================================================
	// register file access helpers
	function automatic logic [23:0] samd_reg_get(input samd_state_s s, input logic [5:0] i);
		logic [23:0] v;
		v = '0;
		case (i)
			6'h00: v[7:0] = s.acc_a[55:48];
			6'h01: v = s.acc_a[47:24];
			6'h02: v = s.acc_a[23:0];
			6'h03: v[7:0] = s.acc_b[55:48];
			6'h04: v = s.acc_b[47:24];
			6'h05: v = s.acc_b[23:0];
			default: begin
				if (i < 6'h0A) v = s.mul_in[2'(i - 6'h06)];
				else if (i < 6'h12) v = s.areg[3'(i - 6'h0A)];
				else v = s.oreg[3'(i - 6'h12)];
			end
		endcase
		return v;
	endfunction

	function automatic samd_state_s samd_reg_set(input samd_state_s s, input logic [5:0] i,
		input logic [23:0] v);
		samd_state_s r;
		r = s;
		case (i)
			6'h00: r.acc_a[55:48] = v[7:0];
			6'h01: r.acc_a[47:24] = v;
			6'h02: r.acc_a[23:0] = v;
			6'h03: r.acc_b[55:48] = v[7:0];
			6'h04: r.acc_b[47:24] = v;
			6'h05: r.acc_b[23:0] = v;
			default: begin
				if (i < 6'h0A) r.mul_in[2'(i - 6'h06)] = v;
				else if (i < 6'h12) r.areg[3'(i - 6'h0A)] = v;
				else r.oreg[3'(i - 6'h12)] = v;
			end
		endcase
		return r;
	endfunction

	// destination write of the updated-address op; a whole accumulator
	// takes the word as its middle part, sign extended, low part cleared
	function automatic samd_state_s samd_dest_set(input samd_state_s s, input logic [4:0] c,
		input logic [23:0] v);
		samd_state_s r;
		r = s;
		if (c[4]) begin
			if (c[3]) r.oreg[c[2:0]] = v;
			else r.areg[c[2:0]] = v;
		end else begin
			case (c[3:0])
				4'h4, 4'h5, 4'h6, 4'h7: r.mul_in[c[1:0]] = v;
				4'h8: r.acc_a[23:0] = v;
				4'h9: r.acc_b[23:0] = v;
				4'hA: r.acc_a[55:48] = v[7:0];
				4'hB: r.acc_b[55:48] = v[7:0];
				4'hC: r.acc_a[47:24] = v;
				4'hD: r.acc_b[47:24] = v;
				4'hE: r.acc_a = {{8{v[23]}}, v, 24'h000000};
				4'hF: r.acc_b = {{8{v[23]}}, v, 24'h000000};
				default: r = s;
			endcase
		end
		return r;
	endfunction

	// read decode: bit 32 says the address is mapped
	function automatic logic [32:0] samd_read(input samd_state_s s, input logic [7:0] a);
		logic [5:0] idx;
		logic [32:0] r;
		idx = 6'((a - SAMD_OFF_REGS) >> 2);
		r = {1'b1, 32'h00000000};
		if (a == SAMD_OFF_INSTR) r[23:0] = s.last_instr;
		else if (a == SAMD_OFF_CTRL) r[0] = s.dp_mode;
		else if (a == SAMD_OFF_CCR) r[7:0] = s.condition_code_reg;
		else if (a == SAMD_OFF_STATUS) r[0] = s.bad_instr;
		else if (a >= SAMD_OFF_REGS && a[1:0] == 2'h0 && idx < SAMD_NUM_REGS) begin
			r[23:0] = samd_reg_get(s, idx);
		end else r[32] = 1'b0;
		return r;
	endfunction

	function automatic logic [31:0] samd_merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
		end
		return r;
	endfunction

	// ==========================================================
	// bus side values
	logic [32:0] rd_res, wr_old;
	logic [31:0] wr_val;
	logic [23:0] ins;
	logic do_write, exec;
	logic [5:0] wr_idx;

	assign rd_res = samd_read(q, axil_req_i.araddr);
	assign wr_old = samd_read(q, q.awaddr);
	// partial strobes merge into the current contents
	assign wr_val = samd_merge(wr_old[31:0], q.wdata, q.wstrb);
	assign ins = wr_val[23:0];
	assign wr_idx = 6'((q.awaddr - SAMD_OFF_REGS) >> 2);
	assign do_write = q.aw_got && q.w_got && !q.rsp.bvalid;
	assign exec = do_write && q.awaddr == SAMD_OFF_INSTR;

	// ==========================================================
	// logical shift right of the middle word
	logic lsr_hi, is_lsr1, is_lsr_imm, is_lsr_reg, is_lsr, lsr_sel;
	logic [55:0] lsr_acc, lsr_res;
	logic [23:0] cnt_word;
	logic [5:0] sh_cnt;
	logic [24:0] sh_ext;
	logic lua_ea, lua_disp, is_lua;

	assign lsr_hi = ins[23:8] == SAMD_LSR_HI;
	assign is_lsr_imm = lsr_hi && ins[7:6] == SAMD_LSR_IMM_TAG;
	assign is_lsr_reg = lsr_hi && ins[7:4] == SAMD_LSR_REG_TAG && ins[3:1] <= SAMD_SSS_LAST;
	// the move field above is ignored; these patterns would clash with the others
	assign is_lsr1 = !lsr_hi && !is_lua && ins[7:4] == SAMD_LSR1_TAG && ins[2:0] == SAMD_LSR1_LO;
	assign is_lsr = is_lsr1 || is_lsr_imm || is_lsr_reg;
	assign lsr_sel = is_lsr1 ? ins[3] : ins[0];
	assign lsr_acc = lsr_sel ? q.acc_b : q.acc_a;
	// count source: four multiplier inputs, then the two middle words
	assign cnt_word = !ins[3] ? q.mul_in[ins[2:1]] : (ins[1] ? q.acc_b[47:24] : q.acc_a[47:24]);
	always_comb begin
		// register counts above 24 are clamped to 25, which empties word and carry
		if (is_lsr1) sh_cnt = 6'h01;
		else if (is_lsr_imm) sh_cnt = {1'b0, ins[5:1]};
		else if (cnt_word > SAMD_LSR_MAX_CNT) sh_cnt = 6'h19;
		else sh_cnt = cnt_word[5:0];
	end
	// the extra low bit catches the last bit out, zero for no shift
	assign sh_ext = {lsr_acc[47:24], 1'b0} >> sh_cnt;
	assign lsr_res = {lsr_acc[55:48], sh_ext[24:1], lsr_acc[23:0]};

	// ==========================================================
	// load updated address, both spellings share one decode
	logic [23:0] lua_rn, lua_nn, lua_addr;
	logic [4:0] lua_dcode;
	assign lua_ea = ins[23:14] == SAMD_LUA_EA_HI && !ins[13] && ins[7:5] == 3'h0;
	assign lua_disp = ins[23:14] == SAMD_LUA_DISP_HI;
	assign is_lua = lua_ea || lua_disp;
	assign lua_rn = q.areg[ins[10:8]];
	assign lua_nn = q.oreg[ins[10:8]];
	always_comb begin
		if (lua_disp) lua_addr = lua_rn + {{17{ins[13]}}, ins[13:11], ins[7:4]};
		else if (ins[12:11] == SAMD_MM_POST_MINUS_N) lua_addr = lua_rn - lua_nn;
		else if (ins[12:11] == SAMD_MM_POST_PLUS_N) lua_addr = lua_rn + lua_nn;
		else if (ins[12:11] == SAMD_MM_POST_MINUS_1) lua_addr = lua_rn - 24'h000001;
		else lua_addr = lua_rn + 24'h000001;
	end
	// short form names only address and offset registers
	assign lua_dcode = lua_disp ? {1'b1, ins[3:0]} : ins[4:0];

	// ==========================================================
	// multiply-accumulate
	logic is_mac1, is_mac2, is_mac, dp_step;
	logic [2:0] mac_q;
	logic [1:0] s1_idx, s2_idx;
	logic [23:0] w1, w2;
	logic [24:0] op1, op2;
	logic signed [49:0] p50;
	logic [55:0] prod, mac_acc, mac_base, mac_add, mac_res;
	logic mac_v;
	logic [7:0] mac_ccr;

	assign is_mac2 = ins[23:13] == SAMD_MAC2_HI && ins[7:6] == 2'h3 && ins[1:0] == SAMD_MAC_LO;
	assign is_mac1 = !is_mac2 && !lsr_hi && !is_lua && ins[7] && ins[1:0] == SAMD_MAC_LO;
	assign is_mac = is_mac1 || is_mac2;
	assign mac_q = ins[6:4];
	assign s1_idx = is_mac2 ? SAMD_QQ_SRC[ins[5:4]] : SAMD_QQQ_S1[mac_q];
	assign s2_idx = SAMD_QQQ_S2[mac_q];
	assign w1 = q.mul_in[s1_idx];
	assign w2 = q.mul_in[s2_idx];
	// double precision steps: low word unsigned, accumulator moved down
	assign dp_step = q.dp_mode && is_mac1 &&
		(mac_q == SAMD_DP_XH_YL || mac_q == SAMD_DP_XL_YH || mac_q == SAMD_DP_YH_XH);
	assign op1 = {(dp_step && mac_q == SAMD_DP_XL_YH) ? 1'b0 : w1[23], w1};
	assign op2 = {(dp_step && mac_q == SAMD_DP_XH_YL) ? 1'b0 : w2[23], w2};
	assign p50 = $signed(op1) * $signed(op2);
	// fractional alignment; the immediate form scales by two^-n instead
	assign prod = is_mac2 ? 56'($signed({{8{w1[23]}}, w1, 24'h000000}) >>> ins[12:8])
		: {{5{p50[49]}}, p50, 1'b0};
	assign mac_acc = ins[3] ? q.acc_b : q.acc_a;
	assign mac_base = dp_step ? 56'($signed(mac_acc) >>> 24) : mac_acc;
	assign mac_add = ins[2] ? -prod : prod;
	assign mac_res = mac_base + mac_add;
	assign mac_v = mac_base[55] == mac_add[55] && mac_res[55] != mac_base[55];
	always_comb begin
		// no scaling mode: growth watched at bits 46 and 45
		mac_ccr = q.condition_code_reg;
		mac_ccr[SAMD_CC_V] = mac_v;
		mac_ccr[SAMD_CC_L] = q.condition_code_reg[SAMD_CC_L] | mac_v;
		mac_ccr[SAMD_CC_N] = mac_res[55];
		mac_ccr[SAMD_CC_Z] = mac_res == 56'h0;
		mac_ccr[SAMD_CC_E] = !(&mac_res[55:47] || ~|mac_res[55:47]);
		mac_ccr[SAMD_CC_U] = !(mac_res[47] ^ mac_res[46]);
		mac_ccr[SAMD_CC_S] = q.condition_code_reg[SAMD_CC_S] | (mac_res[46] ^ mac_res[45]);
	end

	// ==========================================================
	// next state: bus handshakes, register writes, execution
	always_comb begin
		d = q;
		if (q.rsp.rvalid && axil_req_i.rready) d.rsp.rvalid = 1'b0;
		if (axil_req_i.arvalid && q.rsp.arready) begin
			d.rsp.rvalid = 1'b1;
			d.rsp.rdata = rd_res[31:0];
			d.rsp.rresp = rd_res[32] ? SAMD_RESP_OKAY : SAMD_RESP_SLVERR;
		end
		d.rsp.arready = !d.rsp.rvalid;
		if (q.rsp.bvalid && axil_req_i.bready) d.rsp.bvalid = 1'b0;
		// address and data are taken in either order and held
		if (axil_req_i.awvalid && q.rsp.awready) begin
			d.aw_got = 1'b1;
			d.awaddr = axil_req_i.awaddr;
		end
		if (axil_req_i.wvalid && q.rsp.wready) begin
			d.w_got = 1'b1;
			d.wdata = axil_req_i.wdata;
			d.wstrb = axil_req_i.wstrb;
		end
		if (do_write) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.rsp.bvalid = 1'b1;
			d.rsp.bresp = wr_old[32] ? SAMD_RESP_OKAY : SAMD_RESP_SLVERR;
			if (q.awaddr == SAMD_OFF_INSTR) begin
				d.last_instr = ins;
				d.bad_instr = 1'b0;
				if (is_lsr) begin
					if (lsr_sel) d.acc_b = lsr_res;
					else d.acc_a = lsr_res;
					// S, L, E and U are left as they were
					d.condition_code_reg[SAMD_CC_C] = sh_ext[0];
					d.condition_code_reg[SAMD_CC_V] = 1'b0;
					d.condition_code_reg[SAMD_CC_N] = sh_ext[24];
					d.condition_code_reg[SAMD_CC_Z] = sh_ext[24:1] == 24'h0;
				end else if (is_mac) begin
					if (ins[3]) d.acc_b = mac_res;
					else d.acc_a = mac_res;
					d.condition_code_reg = mac_ccr;
				end else if (is_lua && lua_dcode >= SAMD_D_FIRST) begin
					d = samd_dest_set(d, lua_dcode, lua_addr);
				end else d.bad_instr = 1'b1;
			end else if (q.awaddr == SAMD_OFF_CTRL) d.dp_mode = wr_val[0];
			else if (q.awaddr == SAMD_OFF_CCR) d.condition_code_reg = wr_val[7:0];
			else if (q.awaddr != SAMD_OFF_STATUS && wr_old[32]) begin
				d = samd_reg_set(d, wr_idx, wr_val[23:0]);
			end
		end
		d.rsp.awready = !d.aw_got;
		d.rsp.wready = !d.w_got;
	end

	// state register
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) q <= SAMD_STATE_RST;
		else q <= d;
	end

	assign axil_rsp_o = q.rsp;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	lsr_word_a: assert property (exec && is_lsr && !lsr_sel |=>
		q.acc_a[47:24] == ($past(q.acc_a[47:24]) >> $past(sh_cnt)))
		else $error("shifted word wrong");
	// shift: carry, untouched fields and flags
	lsr_carry_a: assert property (exec && is_lsr1 |=>
		q.condition_code_reg[SAMD_CC_C] == $past(lsr_acc[24]) &&
		!($past(lsr_sel) ? q.acc_b[47] : q.acc_a[47]))
		else $error("single shift carry wrong");
	lsr_zero_cnt_a: assert property (exec && is_lsr && sh_cnt == 6'h00 |=>
		!q.condition_code_reg[SAMD_CC_C] && q.acc_a == $past(q.acc_a) && q.acc_b == $past(q.acc_b))
		else $error("zero count changed state");
	lsr_keep_a: assert property (exec && is_lsr |=>
		q.acc_a[55:48] == $past(q.acc_a[55:48]) &&
		q.acc_a[23:0] == $past(q.acc_a[23:0]) &&
		q.acc_b[55:48] == $past(q.acc_b[55:48]) &&
		q.acc_b[23:0] == $past(q.acc_b[23:0]))
		else $error("shift touched other bits");
	lsr_flags_a: assert property (exec && is_lsr |=> !q.condition_code_reg[SAMD_CC_V] &&
		q.condition_code_reg[SAMD_CC_E] == $past(q.condition_code_reg[SAMD_CC_E]) && q.condition_code_reg[SAMD_CC_U] == $past(q.condition_code_reg[SAMD_CC_U]))
		else $error("shift flags wrong");
	// sign and zero judged from the word actually written back
	lsr_nz_a: assert property (exec && is_lsr |=>
		q.condition_code_reg[SAMD_CC_N] == ($past(lsr_sel) ? q.acc_b[47] : q.acc_a[47]) &&
		q.condition_code_reg[SAMD_CC_Z] == (($past(lsr_sel) ? q.acc_b[47:24] : q.acc_a[47:24]) == 24'h0))
		else $error("shift sign or zero flag wrong");
	// address update
	lua_src_keep_a: assert property (exec && is_lua && lua_dcode[4:3] == 2'h2 |=>
		q.areg[$past(lua_dcode[2:0])] == $past(lua_addr) &&
		($past(lua_dcode[2:0]) == $past(ins[10:8]) ||
		q.areg[$past(ins[10:8])] == $past(lua_rn)))
		else $error("updated address wrong");
	lua_disp_a: assert property (exec && lua_disp && !ins[3] |=>
		q.areg[$past(ins[2:0])] ==
		$past(lua_rn) + 24'($signed($past({ins[13:11], ins[7:4]}))))
		else $error("displacement address wrong");
	// multiply-accumulate and bus
	mac_acc_a: assert property (exec && is_mac && !ins[3] && !dp_step |=>
		q.acc_a == $past(q.acc_a) + ($past(ins[2]) ? -$past(prod) : $past(prod)))
		else $error("accumulate wrong");
	mac_carry_a: assert property (exec && is_mac |=>
		q.condition_code_reg[SAMD_CC_C] == $past(q.condition_code_reg[SAMD_CC_C]) &&
		q.condition_code_reg[SAMD_CC_Z] == (($past(ins[3]) ? q.acc_b : q.acc_a) == 56'h0))
		else $error("accumulate flags wrong");
	mac_limit_a: assert property (exec && is_mac |=>
		q.condition_code_reg[SAMD_CC_L] == ($past(q.condition_code_reg[SAMD_CC_L]) | q.condition_code_reg[SAMD_CC_V]))
		else $error("limit flag wrong");
	bus_resp_a: assert property (do_write |=> q.rsp.bvalid && q.rsp.awready && q.rsp.wready)
		else $error("write answer late");

	lsr_imm_c: cover property (exec && is_lsr_imm && sh_cnt == 6'h17);
	lua_disp_c: cover property (exec && lua_disp);
	mac_dp_c: cover property (exec && dp_step);
	mac_imm_c: cover property (exec && is_mac2 && ins[2]);
	lua_minus_n_c: cover property (exec && lua_ea && ins[12:11] == SAMD_MM_POST_MINUS_N);
endmodule

//--- samd_pkg.sv
/*
 * samd_pkg: constants, bus carriers and state layout for the shift, address
 * and multiply-accumulate datapath. Assumes an AXI4-Lite master on the core
 * clock and a 24-bit instruction word written into the instruction register.
 */
package samd_pkg;
	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] SAMD_OFF_INSTR = 8'h00;
	localparam logic [7:0] SAMD_OFF_CTRL = 8'h04;
	localparam logic [7:0] SAMD_OFF_CCR = 8'h08;
	localparam logic [7:0] SAMD_OFF_STATUS = 8'h0C;
	localparam logic [7:0] SAMD_OFF_REGS = 8'h40;
	localparam logic [5:0] SAMD_NUM_REGS = 6'h1A;
	localparam logic [1:0] SAMD_RESP_OKAY = 2'h0;
	localparam logic [1:0] SAMD_RESP_SLVERR = 2'h2;
	// ==========================================================
	// condition code bit positions
	localparam int SAMD_CC_C = 0;
	localparam int SAMD_CC_V = 1;
	localparam int SAMD_CC_Z = 2;
	localparam int SAMD_CC_N = 3;
	localparam int SAMD_CC_U = 4;
	localparam int SAMD_CC_E = 5;
	localparam int SAMD_CC_L = 6;
	localparam int SAMD_CC_S = 7;
	// ==========================================================
	// opcode patterns
	localparam logic [15:0] SAMD_LSR_HI = 16'h0C1E;
	localparam logic [1:0] SAMD_LSR_IMM_TAG = 2'h3;
	localparam logic [3:0] SAMD_LSR_REG_TAG = 4'h3;
	localparam logic [3:0] SAMD_LSR1_TAG = 4'h2;
	localparam logic [2:0] SAMD_LSR1_LO = 3'h3;
	localparam logic [2:0] SAMD_SSS_LAST = 3'h5;
	localparam logic [23:0] SAMD_LSR_MAX_CNT = 24'h000018;
	localparam logic [9:0] SAMD_LUA_EA_HI = 10'h011;
	localparam logic [9:0] SAMD_LUA_DISP_HI = 10'h010;
	localparam logic [10:0] SAMD_MAC2_HI = 11'h008;
	localparam logic [1:0] SAMD_MAC_LO = 2'h2;
	localparam logic [1:0] SAMD_MM_POST_MINUS_N = 2'h0;
	localparam logic [1:0] SAMD_MM_POST_PLUS_N = 2'h1;
	localparam logic [1:0] SAMD_MM_POST_MINUS_1 = 2'h2;
	localparam logic [4:0] SAMD_D_FIRST = 5'h04;
	// operand index: 0 xlow, 1 xhigh, 2 ylow, 3 yhigh
	localparam logic [7:0][1:0] SAMD_QQQ_S1 = 16'hD8D8;
	localparam logic [7:0][1:0] SAMD_QQQ_S2 = 16'h6388;
	localparam logic [3:0][1:0] SAMD_QQ_SRC = 8'h63;
	localparam logic [2:0] SAMD_DP_XH_YL = 3'h6;
	localparam logic [2:0] SAMD_DP_XL_YH = 3'h4;
	localparam logic [2:0] SAMD_DP_YH_XH = 3'h7;
	// ==========================================================
	// bus carriers and state
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} samd_axil_req_s;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} samd_axil_rsp_s;
	typedef struct packed {
		samd_axil_rsp_s rsp;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [55:0] acc_a;
		logic [55:0] acc_b;
		logic [3:0][23:0] mul_in;
		logic [7:0][23:0] areg;
		logic [7:0][23:0] oreg;
		logic [7:0] condition_code_reg;
		logic dp_mode;
		logic [23:0] last_instr;
		logic bad_instr;
	} samd_state_s;
	localparam samd_state_s SAMD_STATE_RST = '0;
endpackage

//--- testbench.sv
/*
 * testbench: self-checking bench for samd_datapath. Drives instructions and
 * operands over AXI4-Lite and compares registers and flags with values
 * reckoned here.
 * Assumes samd_pkg is compiled first and one 100 MHz clock with a
 * synchronous reset.
 */
`timescale 1ns/1ns
module testbench;
	import samd_pkg::*;
	// ==========================================================
	// signals and tables
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	samd_axil_req_s req = '0;
	samd_axil_rsp_s rsp;
	int err_total = 0;
	int cmp_count = 0;
	logic [1:0] resp_q;
	logic [31:0] data_q;
	logic [23:0] mi [4] = '{24'h400000, 24'hC00000, 24'h200000, 24'h7FFFFF};
	int cnt [4] = '{0, 4, 23, 13};
	logic [23:0] smid [4] = '{24'hC00003, 24'hF0F0F0, 24'h800000, 24'h555555};
	int sreg [6] = '{6, 7, 8, 9, 1, 4};
	logic [23:0] lua_exp [4] = '{24'h0000F0, 24'h000110, 24'h0000FF, 24'h000101};

	samd_datapath uut (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.axil_req_i(req),
		.axil_rsp_o(rsp)
	);

	// free-running core clock, 10 ns period
	always #5 clk_sys_i = ~clk_sys_i;

	// ==========================================================
	// helpers
	function automatic logic [7:0] ra(input int i);
		return SAMD_OFF_REGS + 8'(4 * i);
	endfunction

	// fractional product, sign-extended to the accumulator width
	function automatic logic [55:0] fmul(input logic [23:0] a, input logic [23:0] b);
		logic signed [55:0] t;
		t = $signed(a) * $signed(b);
		return t <<< 1;
	endfunction

	// source placed in the middle word, scaled by two to the minus n
	function automatic logic [55:0] imm(input logic [23:0] s, input int n);
		logic signed [55:0] t;
		t = $signed({s, 24'h000000});
		return t >>> n;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		cmp_count++;
		if (seen !== expv) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask

	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ==========================================================
	// bus master: readies are flop outputs, so sampling them at the
	// falling edge tells which rising edge completes the handshake
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_t, w_t, aw_d, w_d;
		aw_d = 1'b0;
		w_d = 1'b0;
		@(posedge clk_sys_i);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		while (!(aw_d && w_d)) begin
			@(negedge clk_sys_i);
			aw_t = !aw_d && rsp.awready === 1'b1;
			w_t = !w_d && rsp.wready === 1'b1;
			@(posedge clk_sys_i);
			if (aw_t) begin
				aw_d = 1'b1;
				req.awvalid <= 1'b0;
			end
			if (w_t) begin
				w_d = 1'b1;
				req.wvalid <= 1'b0;
			end
		end
		do @(negedge clk_sys_i); while (rsp.bvalid !== 1'b1);
		resp_q = rsp.bresp;
		@(posedge clk_sys_i);
		req.bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys_i);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do @(negedge clk_sys_i); while (rsp.arready !== 1'b1);
		@(posedge clk_sys_i);
		req.arvalid <= 1'b0;
		do @(negedge clk_sys_i); while (rsp.rvalid !== 1'b1);
		data_q = rsp.rdata;
		resp_q = rsp.rresp;
		@(posedge clk_sys_i);
		req.rready <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		check(data_q, e);
	endtask

	// ==========================================================
	// one shift; ext and low words are seeded so stray writes show
	task automatic shift_case(input logic d, input logic [23:0] mid, input logic [23:0] ins,
			input int n);
		int ax;
		logic [23:0] res;
		logic c;
		ax = d ? 3 : 0;
		wr(ra(ax), 32'h000000A5);
		wr(ra(ax + 1), {8'h00, mid});
		wr(ra(ax + 2), 32'h00654321);
		wr(SAMD_OFF_CCR, 32'h000000F3);
		wr(SAMD_OFF_INSTR, {8'h00, ins});
		res = mid >> n;
		c = (n == 0) ? 1'b0 : mid[n - 1];
		rd_chk(ra(ax + 1), {8'h00, res});
		rd_chk(ra(ax), 32'h000000A5);
		rd_chk(ra(ax + 2), 32'h00654321);
		rd_chk(SAMD_OFF_CCR, {24'h0, 4'hF, res[23], res == 24'h0, 1'b0, c});
	endtask

	// one multiply-accumulate; carry starts set and must survive
	task automatic mac_case(input logic [23:0] ins, input int ax, input logic [55:0] a0,
			input logic [55:0] ev);
		wr(ra(ax), {24'h0, a0[55:48]});
		wr(ra(ax + 1), {8'h00, a0[47:24]});
		wr(ra(ax + 2), {8'h00, a0[23:0]});
		wr(SAMD_OFF_CCR, 32'h00000001);
		wr(SAMD_OFF_INSTR, {8'h00, ins});
		rd_chk(ra(ax), {24'h0, ev[55:48]});
		rd_chk(ra(ax + 1), {8'h00, ev[47:24]});
		rd_chk(ra(ax + 2), {8'h00, ev[23:0]});
		rd_chk(SAMD_OFF_CCR, {24'h0, ev[46] ^ ev[45], 1'b0,
			!(ev[55:47] == 9'h000 || ev[55:47] == 9'h1FF), ev[47] == ev[46], ev[55],
			ev == 56'h0, 1'b0, 1'b1});
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (10) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rd_chk(SAMD_OFF_CCR, 32'h0);
		rd_chk(ra(10), 32'h0);
		rd(8'hFC);
		check({30'h0, resp_q}, {30'h0, SAMD_RESP_SLVERR});
		wr(8'h41, 32'h1);
		check({30'h0, resp_q}, {30'h0, SAMD_RESP_SLVERR});
		shift_case(1'b0, 24'h800001, 24'h200023, 1);
		shift_case(1'b1, 24'h000001, 24'h20002B, 1);
		// counts kept within the legal range
		for (int i = 0; i < 4; i++) begin
			shift_case(i[0], smid[i], 24'h0C1EC0 | 24'(cnt[i] << 1) | 24'(i[0]), cnt[i]);
		end
		for (int s = 0; s < 6; s++) begin
			wr(ra(sreg[s]), 32'(s + 2));
			// a middle-word count shifts the other accumulator so the count survives
			shift_case(s == 4, 24'hABCDEF, 24'h0C1E30 | 24'(s << 1) | 24'(s == 4), s + 2);
		end
		wr(SAMD_OFF_INSTR, 32'h000C1E3C);
		rd_chk(SAMD_OFF_STATUS, 32'h1);
		// updated address from address register 3 and offset register 3
		wr(ra(13), 32'h00000100);
		wr(ra(21), 32'h00000010);
		for (int m = 0; m < 4; m++) begin
			wr(SAMD_OFF_INSTR, 32'h00044000 | 32'(m << 11) | 32'h00000315);
			rd_chk(ra(15), {8'h00, lua_exp[m]});
			rd_chk(ra(13), 32'h00000100);
		end
		wr(SAMD_OFF_INSTR, 32'h00045B1A);
		rd_chk(ra(20), 32'h00000101);
		wr(SAMD_OFF_INSTR, 32'h00043BF9);
		rd_chk(ra(19), 32'h000000FF);
		wr(SAMD_OFF_INSTR, 32'h00041BF2);
		rd_chk(ra(12), 32'h0000013F);
		rd_chk(ra(13), 32'h00000100);
		// multiplier inputs, then register and immediate forms
		for (int i = 0; i < 4; i++) begin
			wr(ra(6 + i), {8'h00, mi[i]});
		end
		mac_case(24'h2000A2, 0, 56'h10, 56'h10 + fmul(mi[1], mi[0]));
		mac_case(24'h2000FE, 3, 56'h0, 56'h0 - fmul(mi[3], mi[1]));
		mac_case(24'h2000C2, 0, 56'h0, fmul(mi[0], mi[3]));
		mac_case(24'h2000DE, 3, 56'h20, 56'h20 - fmul(mi[2], mi[0]));
		mac_case(24'h0101F2, 0, 56'h00100000000000,
			56'h00100000000000 + imm(mi[1], 1));
		mac_case(24'h0105DE, 3, 56'h0, 56'h0 - imm(mi[0], 5));
		wr(SAMD_OFF_CTRL, 32'h1);
		mac_case(24'h2000F2, 0, 56'h00123456789ABC,
			56'h00000000123456 + fmul(mi[3], mi[1]));
		wr(SAMD_OFF_CTRL, 32'h0);
		final_report();
	end

	// watchdog well beyond the expected run of under a thousand cycles
	initial begin
		repeat (30000) @(posedge clk_sys_i);
		err_total++;
		final_report();
	end
endmodule
